// file: core/mgmt_gate_pkg.sv
// package for the management-interrupt virtualization gate
// assumes a single core clock domain; no register bus
package mgmt_gate_pkg;

    // request source classes
    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_INT_SYNC,
        SRC_EXT_SYNC,
        SRC_EXT_ASYNC
    } mgmt_source_t;

    // decision taken on a request
    typedef enum logic [1:0] {
        ACT_NONE,
        ACT_DROP,
        ACT_EXIT,
        ACT_TAKE
    } mgmt_action_t;

    // guest exit code for a management interrupt
    localparam logic [7:0] EXIT_CODE_MGMT = 8'h62;
    localparam logic [7:0] EXIT_CODE_RST = 8'h00;

    // request carrier from the outside world
    typedef struct packed {
        logic valid;
        logic external;
        logic io_sync;
    } mgmt_req_t;

    // management control register value reset
    localparam logic [31:0] CTL_RST = 32'h0000_0000;

endpackage

// file: core/mgmt_pending_flag.sv
// sticky pending flag for a held external request
// assumes synchronous inputs on the core clock
`timescale 1ns/1ps
module mgmt_pending_flag (
    input wire logic clk,
    input wire logic rst,
    input wire logic set_in,
    input wire logic sync_in,
    input wire logic clr_in,
    output logic pend,
    output logic pend_sync
);
    // set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend <= 1'b0;
            pend_sync <= 1'b0;
        end else if (set_in) begin
            pend <= 1'b1;
            pend_sync <= sync_in | (pend & ~clr_in & pend_sync);
        end else if (clr_in) begin
            pend <= 1'b0;
            pend_sync <= 1'b0;
        end
    end
endmodule

// file: core/smi_virtualization_gate.sv
// management-interrupt gate for a virtualizing core
// assumes the core sequencer drives the instruction strobes, one per cycle
//
// Operation
// R1: classify requests: internal, external sync, external async
// R2: flag clear: drop internal, hold external pending
// R3: intercepted internal: exit, nothing pending
// R4: intercepted external: exit, request stays pending
// R5: not intercepted: take internal and external normally
// R6: intercepted exit precedes management mode entry
// R7: unintercepted in guest: enter from guest context
// R8: resume returns to guest, loads save changes
// R9: set-flag instruction takes held external immediately
// R10: hypervisor avoids set-flag with port-sync pending
// R11: full intercepts imply exits are external async
// R12: remap private memory on entry, unmap leaving
// R13: lock bit shows firmware locked control registers
// R14: locked control write raises protection fault
// R15: one pending flag, cleared only when taken
`timescale 1ns/1ps
module smi_virtualization_gate
    import mgmt_gate_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire mgmt_req_t MGMT_INTERRUPT_REQUEST,
    input wire logic GLOBAL_INTERRUPT_FLAG,
    input wire logic INTERCEPT_MGMT,
    input wire logic IN_GUEST,
    input wire logic SET_GLOBAL_FLAG_INSTR,
    input wire logic RESUME_FROM_MGMT_INSTR,
    input wire logic MGMT_REGISTER_LOCK,
    input wire logic CTL_WRITE,
    input wire logic [31:0] CTL_WDATA,
    output logic GUEST_EXIT,
    output logic [7:0] GUEST_EXIT_CODE,
    output logic MGMT_ENTER,
    output logic MGMT_ACTIVE,
    output logic MGMT_FROM_GUEST,
    output logic RESUME_TO_GUEST,
    output logic LOAD_GUEST_STATE,
    output logic MGMT_PRIVATE_MEMORY_MAPPED,
    output logic MGMT_LOCKED,
    output logic GENERAL_PROTECTION_FAULT,
    output logic [31:0] MGMT_CONTROL_REGISTER,
    output logic PENDING,
    output logic PENDING_IO_SYNC,
    output mgmt_source_t LAST_SOURCE,
    output mgmt_action_t LAST_ACTION
);
    mgmt_source_t src;
    mgmt_action_t act_nxt;
    logic take_pend;
    logic set_pend;
    logic take_now;
    logic guest_ctx_r;

    // classify incoming request
    always_comb begin
        if (!MGMT_INTERRUPT_REQUEST.valid) begin
            src = SRC_NONE;
        end else if (!MGMT_INTERRUPT_REQUEST.external) begin
            src = SRC_INT_SYNC; // [R1]
        end else if (MGMT_INTERRUPT_REQUEST.io_sync) begin
            src = SRC_EXT_SYNC; // [R1]
        end else begin
            src = SRC_EXT_ASYNC; // [R1]
        end
    end

    // decide the response from flag and intercept
    always_comb begin
        act_nxt = ACT_NONE;
        set_pend = 1'b0;
        case (src)
            SRC_NONE: act_nxt = ACT_NONE;
            SRC_INT_SYNC: begin
                if (!GLOBAL_INTERRUPT_FLAG) begin
                    act_nxt = ACT_DROP; // [R2]
                end else if (INTERCEPT_MGMT) begin
                    act_nxt = ACT_EXIT; // [R3]
                end else begin
                    act_nxt = ACT_TAKE; // [R5]
                end
            end
            default: begin
                if (!GLOBAL_INTERRUPT_FLAG) begin
                    act_nxt = ACT_NONE;
                    set_pend = 1'b1; // [R2]
                end else if (INTERCEPT_MGMT) begin
                    act_nxt = ACT_EXIT;
                    set_pend = 1'b1; // [R4]
                end else begin
                    act_nxt = ACT_TAKE; // [R5]
                end
            end
        endcase
    end

    // held request released by set-flag instruction while not in management mode
    assign take_pend = PENDING & SET_GLOBAL_FLAG_INSTR & ~MGMT_ACTIVE; // [R9]
    assign take_now = (act_nxt == ACT_TAKE) & ~MGMT_ACTIVE;

    mgmt_pending_flag u_pend (
        .clk(CLK),
        .rst(SYS_RST),
        .set_in(set_pend),
        .sync_in(MGMT_INTERRUPT_REQUEST.io_sync),
        .clr_in(take_pend),
        .pend(PENDING),
        .pend_sync(PENDING_IO_SYNC)
    ); // [R15]

    // guest exit pulse; management entry in the same step comes only from a held request released by the set-flag instruction
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            GUEST_EXIT <= 1'b0;
            GUEST_EXIT_CODE <= EXIT_CODE_RST;
        end else begin
            GUEST_EXIT <= (act_nxt == ACT_EXIT) & ~MGMT_ACTIVE; // [R6]
            if ((act_nxt == ACT_EXIT) && !MGMT_ACTIVE) begin
                GUEST_EXIT_CODE <= EXIT_CODE_MGMT; // [R3] [R4]
            end
        end
    end

    // management mode entry, residence and resume
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MGMT_ENTER <= 1'b0;
            MGMT_ACTIVE <= 1'b0;
            guest_ctx_r <= 1'b0;
            RESUME_TO_GUEST <= 1'b0;
            LOAD_GUEST_STATE <= 1'b0;
        end else begin
            MGMT_ENTER <= (take_now & (act_nxt != ACT_EXIT)) | take_pend;
            RESUME_TO_GUEST <= 1'b0;
            LOAD_GUEST_STATE <= 1'b0;
            if (take_now || take_pend) begin
                MGMT_ACTIVE <= 1'b1;
                guest_ctx_r <= IN_GUEST; // [R7]
            end else if (MGMT_ACTIVE && RESUME_FROM_MGMT_INSTR) begin
                MGMT_ACTIVE <= 1'b0;
                RESUME_TO_GUEST <= guest_ctx_r; // [R8]
                LOAD_GUEST_STATE <= guest_ctx_r; // [R8]
                guest_ctx_r <= 1'b0;
            end
        end
    end

    assign MGMT_FROM_GUEST = guest_ctx_r; // [R7]

    // private memory mapped only while in management mode
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MGMT_PRIVATE_MEMORY_MAPPED <= 1'b0;
        end else if (take_now || take_pend) begin
            MGMT_PRIVATE_MEMORY_MAPPED <= 1'b1; // [R12]
        end else if (MGMT_ACTIVE && RESUME_FROM_MGMT_INSTR) begin
            MGMT_PRIVATE_MEMORY_MAPPED <= 1'b0; // [R12]
        end
    end

    // lock status and guarded control register
    assign MGMT_LOCKED = MGMT_REGISTER_LOCK; // [R13]

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MGMT_CONTROL_REGISTER <= CTL_RST;
            GENERAL_PROTECTION_FAULT <= 1'b0;
        end else begin
            GENERAL_PROTECTION_FAULT <= CTL_WRITE & MGMT_REGISTER_LOCK; // [R14]
            if (CTL_WRITE && !MGMT_REGISTER_LOCK) begin
                MGMT_CONTROL_REGISTER <= CTL_WDATA;
            end
        end
    end

    // record of the last classified request and its decision
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            LAST_SOURCE <= SRC_NONE;
            LAST_ACTION <= ACT_NONE;
        end else if (src != SRC_NONE) begin
            LAST_SOURCE <= src;
            LAST_ACTION <= act_nxt;
        end
    end
endmodule

// file: testbench/mgmt_source_model.sv
// chipset model raising management interrupt request pulses
// assumes the bench calls send just after a falling clock edge
`timescale 1ns/1ps
module mgmt_source_model
    import mgmt_gate_pkg::*;
(
    input wire logic clk,
    output mgmt_req_t req
);
    initial req = '0;
    // one-cycle pulse; idle qualifiers flip so stale values never match
    task automatic send(input logic ext, input logic io);
        req <= '{valid: 1'b1, external: ext, io_sync: io};
        @(negedge clk);
        req <= '{valid: 1'b0, external: !ext, io_sync: !io};
    endtask
endmodule

// file: testbench/smi_gate_properties.sv
// port-level assertions for the management-interrupt gate
// assumes one clock and the asynchronous active-high reset
`timescale 1ns/1ps
module smi_gate_properties
    import mgmt_gate_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire mgmt_req_t MGMT_INTERRUPT_REQUEST,
    input wire logic GLOBAL_INTERRUPT_FLAG,
    input wire logic INTERCEPT_MGMT,
    input wire logic SET_GLOBAL_FLAG_INSTR,
    input wire logic RESUME_FROM_MGMT_INSTR,
    input wire logic MGMT_REGISTER_LOCK,
    input wire logic CTL_WRITE,
    input wire logic GUEST_EXIT,
    input wire logic MGMT_ENTER,
    input wire logic MGMT_ACTIVE,
    input wire logic MGMT_PRIVATE_MEMORY_MAPPED,
    input wire logic GENERAL_PROTECTION_FAULT,
    input wire logic PENDING
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // request qualifiers
    wire logic s = SET_GLOBAL_FLAG_INSTR;
    wire logic r = MGMT_INTERRUPT_REQUEST.valid && !s;
    wire logic v = r && !MGMT_ACTIVE;
    wire logic x = MGMT_INTERRUPT_REQUEST.external;
    wire logic g = GLOBAL_INTERRUPT_FLAG;
    wire logic i = INTERCEPT_MGMT;
    // a new external request in the release cycle is held again when the flag is clear or intercepted, so it is excluded
    wire logic hx = MGMT_INTERRUPT_REQUEST.valid && x;
    AST_DROP: assert property (v && !x && !g |=> !GUEST_EXIT && !MGMT_ENTER)
        else $error("internal request not dropped");
    AST_HOLD: assert property (r && x && !g |=> PENDING && !MGMT_ENTER)
        else $error("external request not held");
    AST_EXIT_INT: assert property (v && !x && g && i && !PENDING |=>
        GUEST_EXIT && !PENDING && !MGMT_ENTER) else $error("internal exit wrong");
    AST_EXIT_EXT: assert property (v && x && g && i |=> GUEST_EXIT && PENDING)
        else $error("external exit wrong");
    AST_TAKE: assert property (v && g && !i |=> MGMT_ENTER && MGMT_PRIVATE_MEMORY_MAPPED)
        else $error("request not taken");
    AST_RELEASE: assert property (s && PENDING && !MGMT_ACTIVE && !hx |=>
        MGMT_ENTER && !PENDING) else $error("held request not released");
    AST_UNMAP: assert property (RESUME_FROM_MGMT_INSTR && MGMT_ACTIVE |=>
        !MGMT_ACTIVE && !MGMT_PRIVATE_MEMORY_MAPPED) else $error("memory not unmapped");
    AST_GPF: assert property (CTL_WRITE |=> GENERAL_PROTECTION_FAULT == $past(MGMT_REGISTER_LOCK))
        else $error("fault on write wrong");
endmodule
bind smi_virtualization_gate smi_gate_properties CHK (.*);

// file: testbench/tb.sv
// self-checking bench for the management-interrupt gate
// assumes the chipset model drives requests; the bench drives the rest at falling edges
`timescale 1ns/1ps
module tb;
    import mgmt_gate_pkg::*;
    logic clk = 0, rst = 1, global_interrupt_flag = 0, icp = 0, ing = 0, sg = 0, rs = 0, lk = 0, cw = 0;
    logic ex, en, act, fg, rg, ld, map, lo, gp, pd, pio;
    logic [31:0] wd = '0, ctl = '0, creg;
    logic [7:0] code;
    mgmt_req_t req;
    mgmt_source_t src;
    mgmt_action_t lact;
    int mismatches = 0, n_checks = 0, seed = 32'h333b3bb4;
    always #25 clk = !clk;
    mgmt_source_model SRC (.clk(clk), .req(req));
    smi_virtualization_gate DUT (.CLK(clk), .SYS_RST(rst), .MGMT_INTERRUPT_REQUEST(req),
        .GLOBAL_INTERRUPT_FLAG(global_interrupt_flag), .INTERCEPT_MGMT(icp), .IN_GUEST(ing),
        .SET_GLOBAL_FLAG_INSTR(sg), .RESUME_FROM_MGMT_INSTR(rs), .MGMT_REGISTER_LOCK(lk),
        .CTL_WRITE(cw), .CTL_WDATA(wd), .GUEST_EXIT(ex), .GUEST_EXIT_CODE(code),
        .MGMT_ENTER(en), .MGMT_ACTIVE(act), .MGMT_FROM_GUEST(fg), .RESUME_TO_GUEST(rg),
        .LOAD_GUEST_STATE(ld), .MGMT_PRIVATE_MEMORY_MAPPED(map), .MGMT_LOCKED(lo),
        .GENERAL_PROTECTION_FAULT(gp), .MGMT_CONTROL_REGISTER(creg), .PENDING(pd),
        .PENDING_IO_SYNC(pio), .LAST_SOURCE(src), .LAST_ACTION(lact));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // exit, entry, pending one cycle after a request
    function automatic logic [2:0] expect_of(input logic g, input logic i, input logic x);
        return !g ? {2'b00, x} : (i ? {2'b10, x} : 3'b010);
    endfunction
    // random modes, lock and writes; async held requests released, port-sync holds reset, entries resumed
    initial begin
        logic [2:0] e;
        logic x, io, w;
        repeat (6) @(negedge clk);
        rst = 0;
        for (int k = 0; k < 300; k++) begin
            {global_interrupt_flag, icp, ing, x, io, lk, cw} = 7'($random(seed));
            wd = $random(seed);
            w = cw;
            SRC.send(x, io);
            cw = 0;
            e = expect_of(global_interrupt_flag, icp, x);
            if (w && !lk) ctl = wd;
            chk("action", {ex, en, pd}, e);
            chk("source", src, x ? (io ? SRC_EXT_SYNC : SRC_EXT_ASYNC) : SRC_INT_SYNC);
            chk("iosync", pio, x && io && e[0]);
            if (!global_interrupt_flag && !x) chk("drop", lact, ACT_DROP);
            if (e[2]) chk("code", code, EXIT_CODE_MGMT);
            chk("gpf", gp, w && lk);
            chk("ctl", creg, ctl);
            chk("lock", lo, lk);
            if (e[0] && io) begin
                // the bench avoids the set-flag instruction with a port-sync hold pending; a reset clears it instead
                rst = 1;
                ctl = CTL_RST;
                @(negedge clk);
                chk("clear", {pd, pio, ex, en, act, map, code}, 14'h0000);
                rst = 0;
            end else if (e[0]) begin
                sg = 1;
                @(negedge clk);
                sg = 0;
                chk("release", {en, pd, map}, 3'b101);
            end
            if (e[1] || (e[0] && !io)) begin
                chk("context", fg, ing);
                rs = 1;
                @(negedge clk);
                rs = 0;
                chk("resume", {act, map, rg, ld}, {2'b00, ing, ing});
            end
            @(negedge clk);
        end
        // held request lost to a reset in mid-run
        global_interrupt_flag = 0;
        SRC.send(1'b1, 1'b0);
        rst = 1;
        @(negedge clk);
        chk("reset", {pd, ex, act, code}, 11'h000);
        rst = 0;
        finish_test();
    end
endmodule
